// ---- bus_slave_model.sv ----
`timescale 1ns/1ps
module bus_slave_model
   import job_interp_pkg::*;
(
   input  wire logic       core_clk,
   input  wire logic       slow,
   input  wire logic       force_err,
   input  wire logic       bus_req_valid,
   output logic            bus_req_ready,
   input  wire bus_kind_t  bus_req_kind,
   input  wire logic [5:0] bus_req_addr,
   input  wire logic [7:0] bus_req_data,
   input  wire logic       bus_req_last,
   output logic            bus_rsp_valid,
   input  wire logic       bus_rsp_ready,
   output logic      [7:0] bus_rsp_data,
   output logic            bus_rsp_err
);
   logic [7:0] got[$];
   int         req_cnt;
   int         tick;
   bus_kind_t  last_kind;
   logic [5:0] last_addr;
   logic [7:0] last_data;

   // one answer beat, held until taken or for at most 64 cycles
   task automatic send(input logic [7:0] v);
      int n;
      n = 0;
      bus_rsp_valid <= 1'b1;
      bus_rsp_data  <= v;
      bus_rsp_err   <= force_err;
      do
      begin
         @(posedge core_clk);
         n++;
      end
      while (!bus_rsp_ready && n < 64);
   endtask

   initial
   begin
      bus_req_ready = 1'b0;
      bus_rsp_valid = 1'b0;
      bus_rsp_data  = 8'h00;
      bus_rsp_err   = 1'b0;
      req_cnt       = 0;
      tick          = 0;
      forever
      begin
         @(posedge core_clk);
         tick++;
         if (bus_req_valid && bus_req_ready)
         begin
            req_cnt++;
            last_kind = bus_req_kind;
            last_addr = bus_req_addr;
            last_data = bus_req_data;
            if (bus_req_kind == KIND_STRING)
               got.push_back(bus_req_data);
            if (bus_req_last)
            begin
               bus_req_ready <= 1'b0;
               repeat (slow ? 20 : 1) @(posedge core_clk);
               if (last_kind == KIND_STRING)
               begin
                  send(8'(got.size()));
                  foreach (got[i])
                     send(~got[i]);
               end
               else
                  send({4'hF, last_addr[3:0] ^ {2'b00, last_kind[1:0]}});
               bus_rsp_valid <= 1'b0;
               bus_rsp_data  <= ~bus_rsp_data;
            end
         end
         bus_req_ready <= !slow || tick[0];
      end
   end
endmodule // bus_slave_model

// ---- job_interp.sv ----
`timescale 1ns/1ps
module job_interp
   import job_interp_pkg::*;
#(
   // arbitrary neutral text: name and firmware version
   parameter logic [8*job_interp_pkg::VER_BYTES-1:0] VERSION_STR =
      {"GENERIC BUS MASTER  FW V1.00.00 "},
   parameter int RSP_DEPTH = 2
)
(
   input  wire logic                     core_clk,
   input  wire logic                     sys_rst,
   input  wire logic                     job_valid,
   output logic                          job_ready,
   input  wire logic [7:0]               job_data,
   input  wire logic                     job_last,
   output logic                          rsp_valid,
   input  wire logic                     rsp_ready,
   output logic      [7:0]               rsp_data,
   output logic                          rsp_last,
   output logic                          job_done,
   output logic                          job_err,
   output logic                          bus_req_valid,
   input  wire logic                     bus_req_ready,
   output job_interp_pkg::bus_kind_t     bus_req_kind,
   output logic      [5:0]               bus_req_addr,
   output logic      [7:0]               bus_req_data,
   output logic                          bus_req_last,
   input  wire logic                     bus_rsp_valid,
   output logic                          bus_rsp_ready,
   input  wire logic [7:0]               bus_rsp_data,
   input  wire logic                     bus_rsp_err,
   input  wire logic                     echo_upd_valid,
   input  wire logic [5:0]               echo_upd_addr,
   input  wire logic [3:0]               echo_upd_data,
   output logic                          cyc_hold,
   output logic      [5:0]               cyc_hold_addr
);
   import job_interp_pkg::*;

   initial
   begin
      if (RSP_DEPTH < 2)
         $error("job_interp needs at least two response buffer entries");
   end

   typedef struct packed {
      state_t                          st;
      logic [7:0]                      cmd;
      logic [5:0]                      addr;
      logic [7:0]                      cnt;
      logic [4:0]                      idx;
      logic                            err;
      logic                            first;
      logic                            done;
      logic                            done_err;
      logic [ECHO_SLOTS*ECHO_W-1:0]    echo;
   } state_q_t;

   state_q_t s_q;
   state_q_t s_d;

   logic       push_valid;
   logic       push_ready;
   logic [7:0] push_data;
   logic       push_last;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic supported(input logic [7:0] c);
      return (c == CMD_ECHO_LIST) || (c == CMD_CTT_REQ) ||
             (c == CMD_VERSION) || (c == CMD_RD_ID) ||
             (c == CMD_RD_XID1) || (c == CMD_WR_XID1);
   endfunction

   // next state once all job bytes are in
   function automatic state_t dispatch(input logic [7:0] c,
                                       input logic       e);
      if (e)
         return ST_DONE;
      else if (c == CMD_VERSION || c == CMD_ECHO_LIST)
         return ST_EMIT;
      else if (c == CMD_CTT_REQ)
         return ST_STR_IN;
      else
         return ST_BUS_REQ;
   endfunction

   function automatic logic [3:0] echo_of(
      input logic [ECHO_SLOTS*ECHO_W-1:0] e,
      input logic [5:0]                   slot);
      return e[{slot, 2'b00} +: ECHO_W];
   endfunction

   // one reply byte of the echo list
   function automatic logic [7:0] echo_byte(
      input logic [ECHO_SLOTS*ECHO_W-1:0] e,
      input logic [4:0]                   n);
      logic [5:0] hi;
      logic [5:0] lo;
      logic [3:0] j;
      hi = '0;
      lo = '0;
      j  = '0;
      if (n == 5'd0)
         return {echo_of(e, 6'd30), echo_of(e, 6'd31)};
      else if (n < 5'd16)
      begin
         j  = 4'(n - 5'd1);
         hi = {1'b0, j, 1'b0};
         lo = {1'b0, j, 1'b1};
      end
      else
      begin
         j  = n[3:0];
         hi = B_BANK_BASE | {1'b0, j, 1'b0};
         lo = B_BANK_BASE | {1'b0, j, 1'b1};
      end
      // the nibble beside slave 1 and 1B is unused
      if (j == 4'd0)
         return {RSVD_NIBBLE, echo_of(e, lo)};
      return {echo_of(e, hi), echo_of(e, lo)};
   endfunction

   function automatic bus_kind_t kind_of(input logic [7:0] c);
      if (c == CMD_RD_ID)
         return KIND_RD_ID;
      else if (c == CMD_RD_XID1)
         return KIND_RD_XID1;
      else
         return KIND_WR_XID1;
   endfunction

   // ----------------------------------------------------------------
   // interpreter
   // ----------------------------------------------------------------
   always_comb
   begin
      s_d           = s_q;
      s_d.done      = 1'b0;
      s_d.done_err  = 1'b0;
      job_ready     = 1'b0;
      bus_req_valid = 1'b0;
      bus_req_kind  = KIND_STRING;
      bus_req_addr  = s_q.addr;
      bus_req_data  = job_data;
      bus_req_last  = 1'b0;
      bus_rsp_ready = 1'b0;
      push_valid    = 1'b0;
      push_data     = '0;
      push_last     = 1'b0;

      // latest parameter reply per slave
      if (echo_upd_valid)
         s_d.echo[{echo_upd_addr, 2'b00} +: ECHO_W] =
            echo_upd_data;

      case (s_q.st)
         ST_IDLE:
         begin
            job_ready = 1'b1;
            if (job_valid)
            begin
               s_d.cmd = job_data;
               s_d.err = !supported(job_data);
               if (job_last)
               begin
                  if (job_data != CMD_VERSION)
                     s_d.err = 1'b1;
                  s_d.st = dispatch(job_data, s_d.err);
               end
               else if (!supported(job_data) || job_data == CMD_VERSION)
                  s_d.st = ST_DRAIN;
               else
                  s_d.st = ST_ARG;
            end
         end

         ST_ARG:
         begin
            job_ready = 1'b1;
            if (job_valid)
            begin
               s_d.addr = job_data[5:0];
               if (s_q.cmd == CMD_ECHO_LIST && job_data != ECHO_ARG)
                  s_d.err = 1'b1;
               if (s_q.cmd == CMD_WR_XID1)
               begin
                  s_d.addr = WR_XID1_ADDR;
                  s_d.cnt  = {RSVD_NIBBLE, job_data[3:0]};
               end
               if (s_q.cmd == CMD_CTT_REQ)
                  s_d.st = job_last ? ST_DONE : ST_CNT;
               else
                  s_d.st = job_last ? dispatch(s_q.cmd, s_d.err) : ST_DRAIN;
               if (s_q.cmd == CMD_CTT_REQ && job_last)
                  s_d.err = 1'b1;
            end
         end

         ST_CNT:
         begin
            job_ready = 1'b1;
            if (job_valid)
            begin
               s_d.cnt = job_data;
               if (job_data == 8'h00 || job_data > STR_MAX_BYTES || job_last)
               begin
                  s_d.err = 1'b1;
                  s_d.st  = job_last ? ST_DONE : ST_DRAIN;
               end
               else
                  s_d.st = ST_STR_OUT;
            end
         end

         ST_STR_OUT:
         begin
            // bytes go out as they come, contents untouched
            bus_req_valid = job_valid;
            bus_req_data  = job_data;
            bus_req_last  = (s_q.cnt == 8'd1) || job_last;
            job_ready     = bus_req_ready;
            if (job_valid && bus_req_ready)
            begin
               s_d.cnt = s_q.cnt - 8'd1;
               if (bus_req_last)
               begin
                  if (s_q.cnt != 8'd1)
                     s_d.err = 1'b1;
                  s_d.first = 1'b1;
                  s_d.st    = job_last ? ST_STR_IN : ST_DRAIN;
               end
            end
         end

         ST_DRAIN:
         begin
            job_ready = 1'b1;
            if (job_valid && job_last)
            begin
               s_d.first = 1'b1;
               s_d.st    = dispatch(s_q.cmd, s_q.err);
            end
         end

         ST_BUS_REQ:
         begin
            // diagnostic reads go to the slave itself
            bus_req_valid = 1'b1;
            bus_req_kind  = kind_of(s_q.cmd);
            bus_req_data  = s_q.cnt;
            bus_req_last  = 1'b1;
            if (bus_req_ready)
               s_d.st = ST_BUS_WAIT;
         end

         ST_BUS_WAIT:
         begin
            bus_rsp_ready = (s_q.cmd == CMD_WR_XID1) || push_ready;
            push_valid    = bus_rsp_valid && !bus_rsp_err &&
                            (s_q.cmd != CMD_WR_XID1);
            push_data     = {RSVD_NIBBLE, bus_rsp_data[3:0]};
            push_last     = 1'b1;
            if (bus_rsp_valid && bus_rsp_ready)
            begin
               s_d.err = bus_rsp_err;
               s_d.st  = ST_DONE;
            end
         end

         ST_STR_IN:
         begin
            // byte 0 is the count, then the string, both as received
            bus_rsp_ready = s_q.err || push_ready;
            push_valid    = bus_rsp_valid && !bus_rsp_err && !s_q.err;
            push_data     = bus_rsp_data;
            push_last     = s_q.first ? (bus_rsp_data == 8'h00)
                                      : (s_q.cnt == 8'd1);
            if (bus_rsp_valid && bus_rsp_ready)
            begin
               s_d.first = 1'b0;
               s_d.cnt   = s_q.first ? bus_rsp_data : s_q.cnt - 8'd1;
               if (bus_rsp_err)
               begin
                  s_d.err = 1'b1;
                  s_d.st  = ST_DONE;
               end
               else if (push_last)
                  s_d.st = ST_DONE;
            end
         end

         ST_EMIT:
         begin
            push_valid = 1'b1;
            push_last  = (s_q.idx == 5'(ECHO_BYTES - 1));
            if (s_q.cmd == CMD_VERSION)
               push_data = VERSION_STR[8*(VER_BYTES-1-int'(s_q.idx)) +: 8];
            else
               push_data = echo_byte(s_q.echo, s_q.idx);
            if (push_ready)
            begin
               s_d.idx = s_q.idx + 5'd1;
               if (push_last)
                  s_d.st = ST_DONE;
            end
         end

         ST_DONE:
         begin
            s_d.done     = 1'b1;
            s_d.done_err = s_q.err;
            s_d.err      = 1'b0;
            s_d.idx      = '0;
            s_d.st       = ST_IDLE;
         end

         default:
            s_d.st = ST_IDLE;
      endcase
   end

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         s_q      <= '0;
         s_q.st   <= ST_IDLE;
         s_q.echo <= ECHO_RESET;
      end
      else
         s_q <= s_d;
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign job_done      = s_q.done;
   assign job_err       = s_q.done_err;
   // cyclic exchange paused while a string is on the bus
   assign cyc_hold      = (s_q.st == ST_STR_OUT) ||
                          (s_q.st == ST_STR_IN) ||
                          (s_q.st == ST_DRAIN && s_q.cmd == CMD_CTT_REQ &&
                           !s_q.err);
   assign cyc_hold_addr = s_q.addr;

   // ----------------------------------------------------------------
   // response buffer
   // ----------------------------------------------------------------
   rsp_buffer
   #(
      .WIDTH (9),
      .DEPTH (RSP_DEPTH)
   )
   u_rsp_buffer
   (
      .core_clk  (core_clk),
      .sys_rst   (sys_rst),
      .in_valid  (push_valid),
      .in_ready  (push_ready),
      .in_data   ({push_last, push_data}),
      .out_valid (rsp_valid),
      .out_ready (rsp_ready),
      .out_data  ({rsp_last, rsp_data})
   );
endmodule // job_interp

// ---- job_interp_pkg.sv ----
package job_interp_pkg;

   // ----------------------------------------------------------------
   // job command codes
   // ----------------------------------------------------------------
   localparam logic [7:0] CMD_ECHO_LIST  = 8'h33;
   localparam logic [7:0] CMD_CTT_REQ    = 8'h44;
   localparam logic [7:0] CMD_VERSION    = 8'h14;
   localparam logic [7:0] CMD_RD_ID      = 8'h17;
   localparam logic [7:0] CMD_RD_XID1    = 8'h37;
   localparam logic [7:0] CMD_WR_XID1    = 8'h3F;
   localparam logic [7:0] ECHO_ARG       = 8'h00;

   // ----------------------------------------------------------------
   // job layout and limits
   // ----------------------------------------------------------------
   localparam int         JOB_MAX_BYTES  = 223;
   localparam int         JOB_HDR_BYTES  = 3;
   localparam logic [7:0] STR_MAX_BYTES  = 8'(JOB_MAX_BYTES - JOB_HDR_BYTES);
   localparam int         VER_BYTES      = 32;
   localparam int         ECHO_BYTES     = 32;
   localparam int         ECHO_SLOTS     = 64;
   localparam int         ECHO_W         = 4;
   localparam logic [5:0] B_BANK_BASE    = 6'h20;
   localparam logic [5:0] WR_XID1_ADDR   = 6'h00;
   localparam logic [3:0] RSVD_NIBBLE    = 4'h0;
   localparam logic [ECHO_SLOTS*ECHO_W-1:0] ECHO_RESET = '0;

   // ----------------------------------------------------------------
   // bus engine request kinds
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      KIND_RD_ID   = 3'h0,
      KIND_RD_XID1 = 3'h1,
      KIND_WR_XID1 = 3'h2,
      KIND_STRING  = 3'h3
   } bus_kind_t;

   // ----------------------------------------------------------------
   // interpreter states
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_IDLE     = 4'h0,
      ST_ARG      = 4'h1,
      ST_CNT      = 4'h3,
      ST_STR_OUT  = 4'h2,
      ST_DRAIN    = 4'h6,
      ST_BUS_REQ  = 4'h7,
      ST_BUS_WAIT = 4'h5,
      ST_STR_IN   = 4'h4,
      ST_EMIT     = 4'hC,
      ST_DONE     = 4'hD
   } state_t;

endpackage

// ---- job_interp_properties.sv ----
`timescale 1ns/1ps
module job_interp_properties
   import job_interp_pkg::*;
(
   input wire logic       core_clk,
   input wire logic       sys_rst,
   input wire logic       job_done,
   input wire logic       rsp_valid,
   input wire logic       rsp_ready,
   input wire logic [7:0] rsp_data,
   input wire logic       rsp_last,
   input wire logic       bus_req_valid,
   input wire logic       bus_req_ready,
   input wire bus_kind_t  bus_req_kind,
   input wire logic [5:0] bus_req_addr,
   input wire logic [7:0] bus_req_data,
   input wire logic       bus_req_last,
   input wire logic       bus_rsp_valid,
   input wire logic       bus_rsp_ready,
   input wire logic       bus_rsp_err,
   input wire logic       cyc_hold,
   input wire logic [5:0] cyc_hold_addr
);
   // ------------------------------------------------------------
   // sequences
   // ------------------------------------------------------------
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (sys_rst);

   sequence s_id_req;
      bus_req_valid && bus_req_ready &&
      (bus_req_kind == KIND_RD_ID || bus_req_kind == KIND_RD_XID1);
   endsequence
   sequence s_ans;
      bus_rsp_valid && bus_rsp_ready;
   endsequence
   sequence s_id_rsp;
      ##[1:8] (rsp_valid && rsp_last && rsp_data[7:4] == RSVD_NIBBLE);
   endsequence

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   done_pulse_a: assert property (job_done |=> !job_done)
      else $error("job done longer than one cycle");
   rsp_hold_a: assert property (rsp_valid && !rsp_ready |=>
      rsp_valid && $stable(rsp_data) && $stable(rsp_last))
      else $error("reply byte dropped while stalled");
   req_hold_a: assert property (bus_req_valid &&
      !bus_req_ready |=> bus_req_valid && $stable(bus_req_data) &&
      $stable(bus_req_addr))
      else $error("bus request changed while stalled");
   wr_slave0_a: assert property (bus_req_valid &&
      bus_req_kind == KIND_WR_XID1 |->
      bus_req_addr == WR_XID1_ADDR && bus_req_data[7:4] == 4'h0)
      else $error("id write not to slave zero");
   single_last_a: assert property (bus_req_valid &&
      bus_req_kind != KIND_STRING |-> bus_req_last)
      else $error("single request without last");
   str_hold_a: assert property (bus_req_valid &&
      bus_req_ready && bus_req_kind == KIND_STRING |=>
      cyc_hold && cyc_hold_addr == $past(bus_req_addr))
      else $error("cyclic exchange not held");
   rst_quiet_a: assert property ($fell(sys_rst) |->
      !rsp_valid && !job_done && !bus_req_valid && !cyc_hold)
      else $error("outputs busy after reset");
   id_reply_a: assert property (
      first_match(s_id_req ##[1:80] s_ans) |-> bus_rsp_err or s_id_rsp)
      else $error("id reply missing or reserved bits set");
endmodule // job_interp_properties

bind job_interp job_interp_properties job_interp_properties_inst (
   .core_clk, .sys_rst, .job_done, .rsp_valid, .rsp_ready, .rsp_data,
   .rsp_last, .bus_req_valid, .bus_req_ready, .bus_req_kind,
   .bus_req_addr, .bus_req_data, .bus_req_last, .bus_rsp_valid,
   .bus_rsp_ready, .bus_rsp_err, .cyc_hold, .cyc_hold_addr
);

// ---- job_interp_tb_top.sv ----
`timescale 1ns/1ps
module job_interp_tb_top;
   import job_interp_pkg::*;

   typedef logic [7:0] byte_q_t[$];
   typedef struct {
      logic [7:0] b[3];
      int         n;
      int         rlen;
      logic [7:0] r0;
      logic       e;
   } row_t;

   localparam logic [255:0] VSTR = "BENCH MASTER UNIT  FW VER 9.8.7 ";

   logic       core_clk, sys_rst, job_valid, job_ready, job_last;
   logic       rsp_valid, rsp_ready, rsp_last, job_done, job_err;
   logic       bus_req_valid, bus_req_ready, bus_req_last, bus_rsp_valid;
   logic       bus_rsp_ready, bus_rsp_err, echo_upd_valid, cyc_hold;
   logic       slow, force_err, stall, held_seen, got_done, seen_err;
   logic [7:0] job_data, rsp_data, bus_req_data, bus_rsp_data;
   logic [5:0] bus_req_addr, echo_upd_addr, cyc_hold_addr;
   logic [3:0] echo_upd_data;
   logic [3:0] em[64];
   bus_kind_t  bus_req_kind;
   byte_q_t    jb, rq;
   row_t       rows[6];
   int         errors, checked, c0;

   job_interp #(.VERSION_STR(VSTR)) job_interp_inst (
      .core_clk, .sys_rst, .job_valid, .job_ready, .job_data, .job_last,
      .rsp_valid, .rsp_ready, .rsp_data, .rsp_last, .job_done, .job_err,
      .bus_req_valid, .bus_req_ready, .bus_req_kind, .bus_req_addr,
      .bus_req_data, .bus_req_last, .bus_rsp_valid, .bus_rsp_ready,
      .bus_rsp_data, .bus_rsp_err, .echo_upd_valid, .echo_upd_addr,
      .echo_upd_data, .cyc_hold, .cyc_hold_addr);

   bus_slave_model m (
      .core_clk, .slow, .force_err, .bus_req_valid, .bus_req_ready,
      .bus_req_kind, .bus_req_addr, .bus_req_data, .bus_req_last,
      .bus_rsp_valid, .bus_rsp_ready, .bus_rsp_data, .bus_rsp_err);

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   always #25 core_clk = ~core_clk;

   always @(posedge core_clk)
      if (cyc_hold && cyc_hold_addr == 6'h07)
         held_seen = 1'b1;

   task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
      checked++;
      if (seen !== exp)
      begin
         errors++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic stop_test;
      $display("checks %0d mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic run_job(input byte_q_t q);
      int i;
      int n;
      int l = 0;
      i = 0;
      n = 0;
      rq.delete();
      got_done = 1'b0;
      fork
         begin
            while (i < q.size())
            begin
               job_valid <= 1'b1;
               job_data  <= q[i];
               job_last  <= (i == q.size() - 1);
               @(posedge core_clk);
               if (job_ready)
                  i++;
            end
            job_valid <= 1'b0;
         end
         while ((!got_done || rsp_valid) && n < 3000)
         begin
            rsp_ready <= !stall || (n % 4 < 2);
            @(posedge core_clk);
            n++;
            if (rsp_valid && rsp_ready)
               rq.push_back(rsp_data);
            l = (rsp_valid && rsp_ready && rsp_last) ? rq.size() : l;
            if (job_done)
            begin
               got_done = 1'b1;
               seen_err = job_err;
            end
         end
      join
      check("job done", {7'h00, got_done}, 8'h01);
      check("last", 8'(l), 8'(rq.size()));
   endtask

   function automatic logic [7:0] exp_echo(input int n);
      int s;
      s = (n < 16) ? 2 * n - 2 : 2 * n;
      if (n == 0)
         return {em[30], em[31]};
      return {(n == 1 || n == 16) ? 4'h0 : em[s], em[s + 1]};
   endfunction

   task automatic check_echo;
      jb = '{CMD_ECHO_LIST, ECHO_ARG};
      run_job(jb);
      check("echo len", 8'(rq.size()), 8'(ECHO_BYTES));
      for (int n = 0; n < 32; n++)
         check("echo", rq[n], exp_echo(n));
      $display("echo list done");
   endtask

   // ------------------------------------------------------------
   // tests
   // ------------------------------------------------------------
   initial
   begin
      core_clk = 0; sys_rst = 1; job_valid = 0; job_data = 0;
      job_last = 0; rsp_ready = 1; echo_upd_valid = 0;
      echo_upd_addr = 0; echo_upd_data = 0; slow = 0; force_err = 0;
      stall = 0; held_seen = 0; errors = 0; checked = 0;
      em = '{default: 4'h0};
      rows = '{'{'{8'h17, 8'h05, 8'h00}, 2, 1, 8'h05, 1'b0},
               '{'{8'h37, 8'h2A, 8'h00}, 2, 1, 8'h0B, 1'b0},
               '{'{8'h3F, 8'hF9, 8'h00}, 2, 0, 8'h00, 1'b0},
               '{'{8'h55, 8'h00, 8'h00}, 1, 0, 8'h00, 1'b1},
               '{'{8'h33, 8'h01, 8'h00}, 2, 0, 8'h00, 1'b1},
               '{'{8'h44, 8'h03, 8'h00}, 3, 0, 8'h00, 1'b1}};
      repeat (20) @(posedge core_clk);
      sys_rst <= 1'b0;
      @(posedge core_clk);
      foreach (rows[k])
      begin
         jb.delete();
         for (int j = 0; j < rows[k].n; j++)
            jb.push_back(rows[k].b[j]);
         c0 = m.req_cnt;
         run_job(jb);
         check("err", {7'h00, seen_err}, {7'h00, rows[k].e});
         check("bus", 8'(m.req_cnt - c0), {7'h00, !rows[k].e});
         check("len", 8'(rq.size()), 8'(rows[k].rlen));
         if (rows[k].rlen > 0)
            check("id", rq[0], rows[k].r0);
         $display("row %0d done", k);
      end
      check("wr kind", {5'h00, m.last_kind}, 8'h02);
      check("wr addr", {2'b00, m.last_addr}, 8'h00);
      check("wr code", m.last_data, 8'h09);
      force_err <= 1'b1;
      jb = '{CMD_RD_ID, 8'h01};
      run_job(jb);
      force_err <= 1'b0;
      check("bus err", {7'h00, seen_err}, 8'h01);
      check("bus err len", 8'(rq.size()), 8'h00);
      $display("bus error done");
      stall = 1'b1;
      jb = '{CMD_VERSION};
      run_job(jb);
      stall = 1'b0;
      check("ver len", 8'(rq.size()), 8'(VER_BYTES));
      for (int i = 0; i < 32; i++)
         check("ver", rq[i], VSTR[8 * (31 - i) +: 8]);
      $display("version done");
      for (int a = 0; a < 64; a++)
      begin
         em[a] = 4'(a) ^ 4'h5;
         echo_upd_valid <= 1'b1;
         echo_upd_addr  <= 6'(a);
         echo_upd_data  <= 4'(a) ^ 4'h5;
         @(posedge core_clk);
      end
      echo_upd_valid <= 1'b0;
      @(posedge core_clk);
      check_echo();
      slow <= 1'b1;
      m.got.delete();
      held_seen = 1'b0;
      jb = '{CMD_CTT_REQ, 8'h07, 8'h03, 8'hA1, 8'hB2, 8'hC3, 8'hDD};
      run_job(jb);
      slow <= 1'b0;
      check("str err", {7'h00, seen_err}, 8'h00);
      check("fwd n", 8'(m.got.size()), 8'h03);
      check("fwd addr", {2'b00, m.last_addr}, 8'h07);
      check("rsp n", rq[0], 8'h03);
      check("rsp len", 8'(rq.size()), 8'h04);
      for (int i = 0; i < 3; i++)
      begin
         check("fwd", m.got[i], jb[i + 3]);
         check("rsp", rq[i + 1], ~jb[i + 3]);
      end
      check("held", {7'h00, held_seen}, 8'h01);
      check("released", {7'h00, cyc_hold}, 8'h00);
      $display("string done");
      sys_rst <= 1'b1;
      repeat (2) @(posedge core_clk);
      sys_rst <= 1'b0;
      @(posedge core_clk);
      em = '{default: 4'h0};
      check_echo();
      stop_test();
   end

   // host gives up on a hung job
   initial
   begin
      repeat (20000) @(posedge core_clk);
      errors++;
      $display("BAD watchdog expected finish seen timeout");
      stop_test();
   end
endmodule // job_interp_tb_top

// ---- rsp_buffer.sv ----
`timescale 1ns/1ps
module rsp_buffer
#(
   parameter int WIDTH = 9,
   parameter int DEPTH = 2
)
(
   input  wire logic             core_clk,
   input  wire logic             sys_rst,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   initial
   begin
      if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
         $error("rsp_buffer depth must be a power of two, at least 2");
   end

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wp;
      logic [AW-1:0]               rp;
      logic [AW:0]                 fill;
   } buf_t;

   buf_t s_q;
   buf_t s_d;
   logic push;
   logic pop;

   // ----------------------------------------------------------------
   // fifo control
   // ----------------------------------------------------------------
   assign in_ready  = (s_q.fill != (AW+1)'(DEPTH));
   assign out_valid = (s_q.fill != '0);
   assign out_data  = s_q.mem[s_q.rp];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_comb
   begin
      s_d = s_q;
      if (push)
      begin
         s_d.mem[s_q.wp] = in_data;
         s_d.wp          = s_q.wp + 1'b1;
      end
      if (pop)
         s_d.rp = s_q.rp + 1'b1;
      if (push && !pop)
         s_d.fill = s_q.fill + 1'b1;
      else if (pop && !push)
         s_d.fill = s_q.fill - 1'b1;
   end

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
         s_q <= '0;
      else
         s_q <= s_d;
   end
endmodule // rsp_buffer
